// ---- pkg/rsq_defines.vh ----
// constants for the reference sync and qualification register bank
// assumes a 50 MHz register clock and word-aligned AXI4-Lite access
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// register indices; byte address is four times the index
`define RSQ_IDX_RATE_A 8'h14
`define RSQ_IDX_RATE_B 8'h15
`define RSQ_IDX_RANGE_A 8'h16
`define RSQ_IDX_RANGE_B 8'h17
`define RSQ_IDX_INHIBIT 8'h1A
`define RSQ_IDX_TIMING 8'h1C
`define RSQ_IDX_EV_STAT 8'h30
`define RSQ_IDX_EV_MASK 8'h31
`define RSQ_IDX_QUAL 8'h32

// reset values
`define RSQ_RST_RANGE 8'h33
`define RSQ_RST_INHIBIT 8'hFF
`define RSQ_RST_TIMING 8'h15

// field positions
`define RSQ_RATE1_LSB 4
`define RSQ_FAIL0_BIT 3
`define RSQ_FAIL1_BIT 7
`define RSQ_MULT_LSB 4
`define RSQ_EV_DROP_LSB 0
`define RSQ_EV_ACCEPT_LSB 3
`define RSQ_EV_PFAIL_LSB 6

// timing: clock rate and soak timer tick
`define RSQ_CLK_MHZ 50
`define RSQ_TICK_US 500

// drop delay choices in microseconds
`define RSQ_DQ_1_US 500
`define RSQ_DQ_2_US 1000
`define RSQ_DQ_3_US 5000
`define RSQ_DQ_4_US 10000
`define RSQ_DQ_5_US 50000
`define RSQ_DQ_6_US 100000
`define RSQ_DQ_7_US 500000
`define RSQ_DQ_8_US 1000000
`define RSQ_DQ_9_US 2000000
`define RSQ_DQ_10_US 2500000
`define RSQ_DQ_11_US 4000000
`define RSQ_DQ_12_US 8000000
`define RSQ_DQ_13_US 16000000
`define RSQ_DQ_15_US 64000000

// accept delay multiples as left shifts of the drop delay
`define RSQ_MULT_SH_0 1
`define RSQ_MULT_SH_1 2
`define RSQ_MULT_SH_2 4
`define RSQ_MULT_SH_3 5

// AXI responses
`define RSQ_RESP_OKAY 2'b00
`define RSQ_RESP_SLVERR 2'b10

`endif

// ---- sim/rsq_regs_sva.sv ----
// checker for the register bank ports
// bound to every rsq_regs instance; one clock domain
`timescale 1ns/10ps

module rsq_regs_sva (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // monitors and outputs
  input wire [2:0] pulse_in0_rate_code,
  input wire [2:0] pulse_in1_rate_code,
  input wire pulse_in0_failed,
  input wire pulse_in1_failed,
  input wire [2:0] ref_a_range_limit,
  input wire [2:0] ref_c_range_limit,
  input wire [2:0] ref_qualified,
  input wire irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // bus answers and their release
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read data");
  property p_r_release;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_release: assert property (p_r_release) else $error("rvalid stuck");
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_release: assert property (p_b_release) else $error("bvalid stuck");
  property p_no_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_no_ar_busy: assert property (p_no_ar_busy) else $error("arready busy");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h000
      |=> s_axi_rresp == 2'b10;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read ok");
  // status layout of the first rate register
  property p_status_a;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h050 ##1
      $stable({pulse_in1_failed, pulse_in1_rate_code}) &&
      $stable({pulse_in0_failed, pulse_in0_rate_code})
      |-> s_axi_rdata == {24'h0, pulse_in1_failed, pulse_in1_rate_code,
      pulse_in0_failed, pulse_in0_rate_code};
  endproperty
  a_status_a: assert property (p_status_a)
    else $error("status layout wrong");
  // reset state of outputs
  property p_rst_range;
    disable iff (1'b0) !aresetn ##1 !aresetn
      |=> ref_a_range_limit == 3'h3 && ref_c_range_limit == 3'h3;
  endproperty
  a_rst_range: assert property (p_rst_range)
    else $error("range reset wrong");
  property p_rst_qual;
    disable iff (1'b0) !aresetn ##1 !aresetn
      |=> ref_qualified == 3'h7 && !irq;
  endproperty
  a_rst_qual: assert property (p_rst_qual)
    else $error("qualify reset wrong");
endmodule // rsq_regs_sva

bind rsq_regs rsq_regs_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .pulse_in0_rate_code(pulse_in0_rate_code),
  .pulse_in1_rate_code(pulse_in1_rate_code),
  .pulse_in0_failed(pulse_in0_failed), .pulse_in1_failed(pulse_in1_failed),
  .ref_a_range_limit(ref_a_range_limit),
  .ref_c_range_limit(ref_c_range_limit),
  .ref_qualified(ref_qualified), .irq(irq));

// ---- sim/rsq_regs_tb_top.sv ----
// self-checking bench for the register bank and soak qualifier
// drives bus and monitors itself; soak tick shortened to 4 cycles
`timescale 1ns/10ps
`define TB_CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module rsq_regs_tb_top;
  // bus and monitor stimulus
  reg aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  reg arv = 1'b0, rry = 1'b0, f0 = 1'b0, f1 = 1'b0, f2 = 1'b0;
  reg [9:0] awa = 10'h000, ara = 10'h000;
  reg [31:0] wd = 32'h0;
  reg [3:0] ws = 4'hF;
  reg [2:0] c0 = 3'h0, c1 = 3'h0, c2 = 3'h0, scm = 3'h0, cfm = 3'h0;
  wire awr, wrdy, bv, arr, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [2:0] la, lb, lc, q;
  integer err_total = 0, n_tests = 0, i;
  reg [31:0] got, exp_v;
  reg [1:0] resp;

  rsq_regs #(.TICK_CYC(15'd4)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .pulse_in0_rate_code(c0),
    .pulse_in1_rate_code(c1), .pulse_in2_rate_code(c2),
    .pulse_in0_failed(f0), .pulse_in1_failed(f1), .pulse_in2_failed(f2),
    .ref_scm_fail(scm), .ref_cfm_fail(cfm), .ref_a_range_limit(la),
    .ref_b_range_limit(lb), .ref_c_range_limit(lc), .ref_qualified(q),
    .irq(irq));

  // clock
  always #10 aclk = ~aclk;

  // expected word of a rate status register
  function [31:0] st(input [2:0] a, input fa, input [2:0] b, input fb);
    st = {24'h0, fb, b, fa, a};
  endfunction

  // verdict and end of run
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // one write, address and data offered together
  task wr(input [7:0] idx, input [31:0] d);
    integer n;
    begin
      awa <= {idx, 2'b00};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wrdy) wv <= 1'b0;
        n = n + 1;
      end while (!bv && n < 200);
      resp = br;
      bry <= 1'b0;
      if (!bv) err_total = err_total + 1;
      if (!bv) give_verdict;
      @(posedge aclk);
    end
  endtask

  // one read
  task rd_t(input [7:0] idx);
    integer n;
    begin
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
        n = n + 1;
      end while (!rv && n < 200);
      got = rd;
      resp = rr;
      rry <= 1'b0;
      if (!rv) err_total = err_total + 1;
      if (!rv) give_verdict;
      @(posedge aclk);
    end
  endtask

  // bounded wait for a qualification level
  task wait_q(input integer b, input v, input integer lim);
    integer n;
    begin
      n = 0;
      while (q[b] !== v && n < lim) begin
        @(posedge aclk);
        n = n + 1;
      end
      `TB_CHK(q[b], v)
    end
  endtask

  initial begin
    void'($urandom(20));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values
    rd_t(8'h16);
    `TB_CHK(got, 32'h33)
    rd_t(8'h17);
    `TB_CHK({got, la, lc}, {32'h33, 6'h1B})
    rd_t(8'h1A);
    `TB_CHK(got, 32'hFF)
    rd_t(8'h1C);
    `TB_CHK(got, 32'h15)
    // every rate code with random failure flags
    for (i = 0; i < 8; i = i + 1) begin
      c0 <= i[2:0];
      c1 <= ~i[2:0];
      c2 <= i[2:0];
      exp_v = $urandom;
      {f0, f1, f2} <= exp_v[2:0];
      @(posedge aclk);
      rd_t(8'h14);
      `TB_CHK(got, st(c0, f0, c1, f1))
      rd_t(8'h15);
      `TB_CHK(got, st(c2, f2, 3'h0, 1'b0))
    end
    // range codes from the loop count with random bits 3 and 7, read back and at the outputs
    for (i = 0; i < 8; i = i + 1) begin
      exp_v = ($urandom & 32'h88) | {25'h0, ~i[2:0], 1'b0, i[2:0]};
      wr(8'h16 + i[0], exp_v);
      rd_t(8'h16 + i[0]);
      `TB_CHK(got, exp_v)
      if (i[0]) `TB_CHK(lc, exp_v[2:0])
      else `TB_CHK({la, lb}, {exp_v[2:0], exp_v[6:4]})
    end
    // refused and ignored accesses
    rd_t(8'h00);
    `TB_CHK(resp, 2'b10)
    wr(8'h3F, 32'hFF);
    `TB_CHK(resp, 2'b10)
    wr(8'h14, 32'hFF);
    rd_t(8'h14);
    `TB_CHK(got, st(c0, f0, c1, f1))
    // inhibited failures keep references a and b
    wr(8'h1A, 32'h09);
    wr(8'h31, 32'h09);
    scm <= 3'h1;
    cfm <= 3'h2;
    repeat (500) @(posedge aclk);
    `TB_CHK(q, 3'h7)
    // coarse failure drops it after 100 ticks of reset timing
    cfm <= 3'h3;
    repeat (300) @(posedge aclk);
    `TB_CHK(q[0], 1'b1)
    wait_q(0, 1'b0, 200);
    repeat (2) @(posedge aclk);
    `TB_CHK(irq, 1'b1)
    `TB_CHK(q[2:1], 2'b11)
    rd_t(8'h30);
    `TB_CHK(got[2:0], 3'h1)
    wr(8'h30, 32'h1);
    @(posedge aclk);
    `TB_CHK(irq, 1'b0)
    // one-tick drop, thirty-two-fold accept, events masked
    wr(8'h1C, 32'h31);
    wr(8'h31, 32'h0);
    cfm <= 3'h0;
    scm <= 3'h0;
    repeat (100) @(posedge aclk);
    `TB_CHK(q[0], 1'b0)
    wait_q(0, 1'b1, 100);
    rd_t(8'h30);
    `TB_CHK({irq, got[5:0]}, 7'h08)
    give_verdict;
  end
endmodule // rsq_regs_tb_top

// ---- src/rsq_regs.v ----
// register bank and guard soak qualifier for three references
// assumes monitor inputs are synchronous to aclk; AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rsq_defines.vh"

module rsq_regs #(
  parameter [14:0] TICK_CYC = `RSQ_TICK_US * `RSQ_CLK_MHZ
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi write address
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi read address
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pulse input monitor results
  input wire [2:0] pulse_in0_rate_code,
  input wire [2:0] pulse_in1_rate_code,
  input wire [2:0] pulse_in2_rate_code,
  input wire pulse_in0_failed,
  input wire pulse_in1_failed,
  input wire pulse_in2_failed,
  // reference monitor results, one bit per reference
  input wire [2:0] ref_scm_fail,
  input wire [2:0] ref_cfm_fail,
  // configuration to the range monitors
  output reg [2:0] ref_a_range_limit,
  output reg [2:0] ref_b_range_limit,
  output reg [2:0] ref_c_range_limit,
  // qualification state and interrupt
  output wire [2:0] ref_qualified,
  output reg irq
);

  // drop delay in soak ticks from the 4-bit code
  function [22:0] dq_ticks;
    input [3:0] code;
    integer t;
    begin
      case (code)
        4'h0: t = 0; // minimum delay possible
        4'h1: t = `RSQ_DQ_1_US / `RSQ_TICK_US;
        4'h2: t = `RSQ_DQ_2_US / `RSQ_TICK_US;
        4'h3: t = `RSQ_DQ_3_US / `RSQ_TICK_US;
        4'h4: t = `RSQ_DQ_4_US / `RSQ_TICK_US;
        4'h5: t = `RSQ_DQ_5_US / `RSQ_TICK_US;
        4'h6: t = `RSQ_DQ_6_US / `RSQ_TICK_US;
        4'h7: t = `RSQ_DQ_7_US / `RSQ_TICK_US;
        4'h8: t = `RSQ_DQ_8_US / `RSQ_TICK_US;
        4'h9: t = `RSQ_DQ_9_US / `RSQ_TICK_US;
        4'hA: t = `RSQ_DQ_10_US / `RSQ_TICK_US;
        4'hB: t = `RSQ_DQ_11_US / `RSQ_TICK_US;
        4'hC: t = `RSQ_DQ_12_US / `RSQ_TICK_US;
        4'hD: t = `RSQ_DQ_13_US / `RSQ_TICK_US;
        default: t = `RSQ_DQ_15_US / `RSQ_TICK_US; // 1110 taken as 1111
      endcase
      dq_ticks = t[22:0];
    end
  endfunction

  // word-aligned address match against a register index
  function hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // software registers
  reg [7:0] range_a_q;
  reg [7:0] range_b_q;
  reg [7:0] inhibit_q;
  reg [7:0] timing_q;
  reg [8:0] ev_stat_q;
  reg [8:0] ev_mask_q;

  // write channel holding state
  reg aw_hold_q;
  reg w_hold_q;
  reg [9:0] awaddr_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;

  // soak tick prescaler
  reg [14:0] tick_cnt_q;
  reg tick_q;

  // previous pulse failure levels for edge events
  reg [2:0] pfail_prev_q;

  wire [2:0] pfail_now;
  wire [2:0] drop_ev;
  wire [2:0] accept_ev;
  wire [8:0] ev_set;
  wire wr_fire;
  wire [22:0] dq_thr;
  reg [22:0] rq_thr;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_ok;

  assign pfail_now = {pulse_in2_failed, pulse_in1_failed, pulse_in0_failed};
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // shared soak thresholds from the timing register
  assign dq_thr = dq_ticks(timing_q[3:0]);
  always @* begin
    case (timing_q[`RSQ_MULT_LSB+1:`RSQ_MULT_LSB])
      2'b00: rq_thr = dq_thr << `RSQ_MULT_SH_0;
      2'b01: rq_thr = dq_thr << `RSQ_MULT_SH_1;
      2'b10: rq_thr = dq_thr << `RSQ_MULT_SH_2;
      default: rq_thr = dq_thr << `RSQ_MULT_SH_3;
    endcase
  end

  // tick every half millisecond
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 15'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYC - 15'h0001) begin
      tick_cnt_q <= 15'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 15'h0001;
      tick_q <= 1'b0;
    end
  end

  // per-reference guard soak timer
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_soak
      reg ok_q;
      reg [22:0] cnt_q;
      wire fail;
      // an inhibited monitor does not feed the timer
      assign fail = (ref_scm_fail[i] & ~inhibit_q[2*i]) |
                    (ref_cfm_fail[i] & ~inhibit_q[2*i+1]);
      assign drop_ev[i] = ok_q && fail && (cnt_q >= dq_thr);
      assign accept_ev[i] = !ok_q && !fail && (cnt_q >= rq_thr);
      assign ref_qualified[i] = ok_q;
      always @(posedge aclk) begin
        if (!aresetn) begin
          ok_q <= 1'b1;
          cnt_q <= 23'h000000;
        end else if (drop_ev[i] || accept_ev[i]) begin
          ok_q <= !ok_q;
          cnt_q <= 23'h000000;
        end else if (fail != ok_q) begin
          cnt_q <= 23'h000000; // condition broke, restart
        end else if (tick_q) begin
          cnt_q <= cnt_q + 23'h000001;
        end
      end
    end
  endgenerate

  assign ev_set = {pfail_now & ~pfail_prev_q, accept_ev, drop_ev};

  // write address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
    end
  end

  // write address decode
  always @* begin
    if (hit(awaddr_q, `RSQ_IDX_RATE_A)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_RATE_B)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_RANGE_A)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_RANGE_B)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_INHIBIT)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_TIMING)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_EV_STAT)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_EV_MASK)) begin
      wr_ok = 1'b1;
    end else if (hit(awaddr_q, `RSQ_IDX_QUAL)) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // register writes, response and event status
  always @(posedge aclk) begin
    if (!aresetn) begin
      range_a_q <= `RSQ_RST_RANGE;
      range_b_q <= `RSQ_RST_RANGE;
      inhibit_q <= `RSQ_RST_INHIBIT;
      timing_q <= `RSQ_RST_TIMING;
      ev_mask_q <= 9'h000;
      ev_stat_q <= 9'h000;
      pfail_prev_q <= 3'b000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSQ_RESP_OKAY;
    end else begin
      pfail_prev_q <= pfail_now;
      if (wr_fire && wstrb0_q) begin
        if (hit(awaddr_q, `RSQ_IDX_RANGE_A)) begin
          range_a_q <= wdata_q[7:0];
        end else if (hit(awaddr_q, `RSQ_IDX_RANGE_B)) begin
          range_b_q <= wdata_q[7:0];
        end else if (hit(awaddr_q, `RSQ_IDX_INHIBIT)) begin
          inhibit_q <= wdata_q[7:0];
        end else if (hit(awaddr_q, `RSQ_IDX_TIMING)) begin
          timing_q <= wdata_q[7:0];
        end else if (hit(awaddr_q, `RSQ_IDX_EV_MASK)) begin
          ev_mask_q <= wdata_q[8:0];
        end
      end
      // write one clears, a new event in the same cycle wins
      if (wr_fire && wstrb0_q && hit(awaddr_q, `RSQ_IDX_EV_STAT)) begin
        ev_stat_q <= (ev_stat_q & ~wdata_q[8:0]) | ev_set;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; reserved bits read zero
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `RSQ_IDX_RATE_A)) begin
      rd_word[2:0] = pulse_in0_rate_code;
      rd_word[`RSQ_FAIL0_BIT] = pulse_in0_failed;
      rd_word[`RSQ_RATE1_LSB+2:`RSQ_RATE1_LSB] = pulse_in1_rate_code;
      rd_word[`RSQ_FAIL1_BIT] = pulse_in1_failed;
    end else if (hit(s_axi_araddr, `RSQ_IDX_RATE_B)) begin
      rd_word[2:0] = pulse_in2_rate_code;
      rd_word[`RSQ_FAIL0_BIT] = pulse_in2_failed;
    end else if (hit(s_axi_araddr, `RSQ_IDX_RANGE_A)) begin
      rd_word[7:0] = range_a_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_RANGE_B)) begin
      rd_word[7:0] = range_b_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_INHIBIT)) begin
      rd_word[7:0] = inhibit_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_TIMING)) begin
      rd_word[7:0] = timing_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_EV_STAT)) begin
      rd_word[8:0] = ev_stat_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_EV_MASK)) begin
      rd_word[8:0] = ev_mask_q;
    end else if (hit(s_axi_araddr, `RSQ_IDX_QUAL)) begin
      rd_word[2:0] = ref_qualified;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel: one read in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RSQ_RESP_OKAY;
    end else begin
      // rises the cycle after rvalid is seen low, drops on an accepted address; never waits on arvalid
      s_axi_arready <= !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // range codes to the monitors and the interrupt level
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_a_range_limit <= 3'b011;
      ref_b_range_limit <= 3'b011;
      ref_c_range_limit <= 3'b011;
      irq <= 1'b0;
    end else begin
      ref_a_range_limit <= range_a_q[2:0];
      ref_b_range_limit <= range_a_q[`RSQ_RATE1_LSB+2:`RSQ_RATE1_LSB];
      ref_c_range_limit <= range_b_q[2:0];
      irq <= |(ev_stat_q & ev_mask_q);
    end
  end

endmodule // rsq_regs
